// ---- sacpf_pkg.sv ----
// Constants and helpers for the converter control block
package sacpf_pkg;

	// Register addresses on the internal bus
	localparam logic [15:0] ADDR_MODE = 16'hff28;
	localparam logic [15:0] ADDR_CHAN = 16'hff29;
	localparam logic [15:0] ADDR_PF_MODE = 16'hff2a;
	localparam logic [15:0] ADDR_PF_THRESH = 16'hff2b;
	localparam logic [15:0] ADDR_RESULT_LO = 16'hff08;
	localparam logic [15:0] ADDR_RESULT_HI = 16'hff09;

	// Reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CHAN_RESET = 8'h00;
	localparam logic [7:0] PF_MODE_RESET = 8'h00;
	localparam logic [7:0] PF_THRESH_RESET = 8'h00;

	// Field layout, writable bit masks
	localparam int MODE_RUN_BIT = 7;
	localparam int MODE_TSEL_LSB = 3;
	localparam int MODE_TSEL_MSB = 5;
	localparam int MODE_REF_BIT = 0;
	localparam logic [7:0] MODE_MASK = 8'hb9;
	localparam logic [7:0] CHAN_MASK = 8'h03;
	localparam int PF_EN_BIT = 7;
	localparam int PF_POL_BIT = 6;
	localparam logic [7:0] PF_MODE_MASK = 8'hc0;
	localparam logic [7:0] PF_THRESH_MASK = 8'hff;

	// Converter geometry
	localparam int RES_BITS = 10;
	localparam int PAD_BITS = 6;
	localparam int CHANNELS = 4;
	localparam logic [RES_BITS-1:0] MSB_TRIAL = 10'h200;

	// Each conversion is 24 equal periods: 14 sampling, 10 bit trials
	localparam int CONV_PERIODS = 24;
	localparam logic [4:0] SAMPLE_LAST = 5'h0d;
	localparam logic [4:0] PHASE_LAST = 5'h17;
	localparam int PERIOD_W = 4;

	// Conversion times in main clock periods per select code
	localparam int CONV_CYC_000 = 288;
	localparam int CONV_CYC_001 = 240;
	localparam int CONV_CYC_010 = 192;
	localparam int CONV_CYC_100 = 144;
	localparam int CONV_CYC_101 = 120;
	localparam int CONV_CYC_110 = 96;

	// Reference generator settling
	localparam int CLK_PERIOD_NS = 20;
	localparam int REF_SETTLE_NS = 14000;
	localparam int REF_SETTLE_CYC =
		(REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REF_CNT_W = 10;

	// Clock periods in one trial period for a select code
	function automatic logic [PERIOD_W-1:0] bit_period(
		input logic [2:0] code);
		case (code)
			3'h1: bit_period = PERIOD_W'(CONV_CYC_001 / CONV_PERIODS);
			3'h2: bit_period = PERIOD_W'(CONV_CYC_010 / CONV_PERIODS);
			3'h4: bit_period = PERIOD_W'(CONV_CYC_100 / CONV_PERIODS);
			3'h5: bit_period = PERIOD_W'(CONV_CYC_101 / CONV_PERIODS);
			3'h6: bit_period = PERIOD_W'(CONV_CYC_110 / CONV_PERIODS);
			// Prohibited codes fall back to the slowest, safest timing
			default: bit_period = PERIOD_W'(CONV_CYC_000 / CONV_PERIODS);
		endcase
	endfunction

endpackage

// ---- sacpf_seq_if.sv ----
// Link between period timer and approximation sequencer
`timescale 1ns/100ps
`default_nettype none
interface sacpf_seq_if;
	import sacpf_pkg::*;
	logic run;
	logic restart;
	logic [PERIOD_W-1:0] period;
	logic tick;
	logic cmp_in;
	logic sample;
	logic [RES_BITS-1:0] approx;
	logic done;
	logic [RES_BITS-1:0] result;

	modport timer (input run, input restart, input period, output tick);
	modport sar (input run, input restart, input tick, input cmp_in,
		output sample, output approx, output done, output result);
	modport ctrl (output run, output restart, output period,
		output cmp_in, input sample, input approx, input done,
		input result);
endinterface
`default_nettype wire

// ---- sacpf_timer.sv ----
// Trial period timer: one tick per conversion period
`timescale 1ns/100ps
`default_nettype none
module sacpf_timer (
	input wire logic clk, // Main clock
	input wire logic rst, // Asynchronous reset, high
	sacpf_seq_if.timer seq // Sequencer link
);
	import sacpf_pkg::*;

	logic [PERIOD_W-1:0] cnt;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			seq.tick <= 1'b0;
		end else if (!seq.run || seq.restart) begin
			cnt <= '0;
			seq.tick <= 1'b0;
		end else if (cnt == seq.period - PERIOD_W'(1)) begin // [R10]
			cnt <= '0;
			seq.tick <= 1'b1;
		end else begin
			cnt <= cnt + PERIOD_W'(1);
			seq.tick <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ---- sacpf_sar.sv ----
// Successive approximation sequencer with sample-and-hold control
`timescale 1ns/100ps
`default_nettype none
module sacpf_sar (
	input wire logic clk, // Main clock
	input wire logic rst, // Asynchronous reset, high
	sacpf_seq_if.sar seq // Timer and control link
);
	import sacpf_pkg::*;

	logic [4:0] phase;
	logic [3:0] bidx;
	logic [RES_BITS-1:0] next_approx;

	assign bidx = 4'(PHASE_LAST - phase);

	// Keep tried bit if input at or above tap, then try the next one
	always_comb begin
		next_approx = seq.approx;
		next_approx[bidx] = seq.cmp_in; // [R21]
		if (bidx != 4'h0)
			next_approx[bidx - 4'h1] = 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= '0;
			seq.sample <= 1'b0;
			seq.approx <= '0;
			seq.done <= 1'b0;
			seq.result <= '0;
		end else begin
			seq.done <= 1'b0;
			if (seq.restart || !seq.run) begin
				phase <= '0;
				seq.sample <= seq.run; // [R5]
				seq.approx <= '0;
			end else if (seq.tick) begin
				if (phase < SAMPLE_LAST) begin
					phase <= phase + 5'h1;
				end else if (phase == SAMPLE_LAST) begin
					seq.sample <= 1'b0; // [R5]
					seq.approx <= MSB_TRIAL; // [R6]
					phase <= phase + 5'h1;
				end else if (phase == PHASE_LAST) begin
					// Tap parks at zero while the next sample is taken
					seq.approx <= '0; // [R5]
					seq.result <= next_approx; // [R6]
					seq.done <= 1'b1;
					seq.sample <= 1'b1; // [R2]
					phase <= '0;
				end else begin
					seq.approx <= next_approx; // [R6]
					phase <= phase + 5'h1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ---- sacpf_top.sv ----
// Control logic for a 10-bit SAR converter with power-fail compare
// Summary of operation
// [R1] Produce 10-bit results from one of four selectable analog channels.
// [R2] With run set, convert the chosen channel repeatedly; interrupt each end.
// [R3] With power-fail compare on, interrupt only when threshold condition holds.
// [R4] Unselected analog pins still serve as digital input port pins.
// [R5] Sample at conversion start, hold until that conversion ends.
// [R6] Resolve bits MSB first, then copy to the result register.
// [R7] Result left-justified in upper 10 bits; low 6 read zero.
// [R8] Mode register takes bit and byte writes; reset clears it.
// [R9] Mode bits: 7 run, 5..3 time select, 0 reference enable.
// [R10] Select codes give 288/240/192/144/120/96 clocks; others prohibited.
// [R11] Software picks a code giving 14 us up to under 100 us.
// [R12] Reference enable powers the generator; it settles after 14 us.
// [R13] Software waits 14 us from reference enable to setting run.
// [R14] Both clear stops; reference only waits; run selects conversion.
// [R15] First result with reference unsettled is treated as unusable.
// [R16] Software stops conversion before changing the time select field.
// [R17] A mode register write inserts a bus wait cycle.
// [R18] Compare enable; polarity picks upper 8 bits >= or < threshold.
// [R19] Channel register low two bits pick channel; upper bits zero.
// [R20] Control or threshold write aborts conversion; restart if run set.
// [R21] Try each bit, sample comparator after settling, clear if below.
`timescale 1ns/100ps
`default_nettype none
module sacpf_top (
	input wire logic CORE_CLK, // Main clock, 50 MHz
	input wire logic RESET, // Asynchronous reset, high
	input wire logic [15:0] BUS_ADDR, // Internal bus byte address
	input wire logic BUS_WR, // Byte write strobe
	input wire logic BUS_BIT_WR, // Single-bit write strobe
	input wire logic [2:0] BUS_BIT_NUM, // Bit number for bit write
	input wire logic [7:0] BUS_WDATA, // Write data, bit value in bit 0
	input wire logic BUS_RD, // Read strobe
	output logic [7:0] BUS_RDATA, // Read data, cycle after strobe
	output logic BUS_WAIT, // One wait cycle after control write or result read
	input wire logic CMP_IN, // Comparator: input at or above tap
	input wire logic [3:0] PIN_IN, // Digital levels of analog pins
	output logic [3:0] PORT_DATA, // Port input data
	output logic [1:0] CHANNEL_SEL, // Analog selector
	output logic SH_SAMPLE, // High sample, low hold
	output logic [9:0] TAP_CODE, // Resistor string tap code
	output logic REF_GEN_EN, // Reference generator power
	output logic CONV_DONE_IRQ // Conversion done, one-cycle pulse
);
	import sacpf_pkg::*;

	sacpf_seq_if seq ();

	logic [7:0] converter_mode_reg;
	logic [7:0] channel_select_reg;
	logic [7:0] powerfail_mode_reg;
	logic [7:0] powerfail_threshold_reg;
	logic [RES_BITS-1:0] conversion_result_reg;
	logic conversion_run;
	logic ref_generator_enable;
	logic powerfail_compare_enable;
	logic powerfail_compare_polarity;
	logic any_wr;
	logic wr_mode;
	logic wr_chan;
	logic wr_pf_mode;
	logic wr_pf_thresh;
	logic hit_mode;
	logic hit_chan;
	logic hit_pf_mode;
	logic hit_pf_thresh;
	logic hit_res_lo;
	logic hit_res_hi;
	// One-hot operating mode from the run and reference bits
	typedef enum logic [2:0] {
		ST_STOPPED = 3'b001,
		ST_WAITING = 3'b010,
		ST_CONVERTING = 3'b100
	} sacpf_op_t;
	sacpf_op_t op_state;
	sacpf_op_t next_op_state;
	logic restart;
	logic [REF_CNT_W-1:0] ref_cnt;
	logic ref_ready;
	logic first_bad;
	logic cond_ge;
	logic fire;
	logic [7:0] next_rdata;

	////////////////////////////////////////////////////////////////
	// Register write path

	// Byte write or read-modify-write of one bit; fixed bits stay zero
	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [7:0] mask);
		logic [7:0] v;
		v = old;
		if (BUS_WR)
			v = BUS_WDATA;
		else
			v[BUS_BIT_NUM] = BUS_WDATA[0];
		merge = v & mask;
	endfunction

	// Address decode shared by the write, read and wait paths
	function automatic logic [5:0] reg_hit(input logic [15:0] a);
		reg_hit = 6'h00;
		if (a == ADDR_MODE)
			reg_hit = 6'h01;
		else if (a == ADDR_CHAN)
			reg_hit = 6'h02;
		else if (a == ADDR_PF_MODE)
			reg_hit = 6'h04;
		else if (a == ADDR_PF_THRESH)
			reg_hit = 6'h08;
		else if (a == ADDR_RESULT_LO)
			reg_hit = 6'h10;
		else if (a == ADDR_RESULT_HI)
			reg_hit = 6'h20;
	endfunction

	assign {hit_res_hi, hit_res_lo, hit_pf_thresh, hit_pf_mode, hit_chan,
		hit_mode} = reg_hit(BUS_ADDR);
	assign any_wr = BUS_WR || BUS_BIT_WR;
	assign wr_mode = any_wr && hit_mode;
	assign wr_chan = any_wr && hit_chan;
	assign wr_pf_mode = any_wr && hit_pf_mode;
	// Threshold takes byte writes only
	assign wr_pf_thresh = BUS_WR && hit_pf_thresh;

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			converter_mode_reg <= MODE_RESET; // [R8]
			channel_select_reg <= CHAN_RESET;
			powerfail_mode_reg <= PF_MODE_RESET;
			powerfail_threshold_reg <= PF_THRESH_RESET;
		end else begin
			if (wr_mode)
				converter_mode_reg <= merge(converter_mode_reg,
					MODE_MASK); // [R8] [R9]
			if (wr_chan)
				channel_select_reg <= merge(channel_select_reg,
					CHAN_MASK); // [R19]
			if (wr_pf_mode)
				powerfail_mode_reg <= merge(powerfail_mode_reg,
					PF_MODE_MASK); // [R18]
			if (wr_pf_thresh)
				powerfail_threshold_reg <= BUS_WDATA & PF_THRESH_MASK;
		end
	end

	assign conversion_run = converter_mode_reg[MODE_RUN_BIT]; // [R9]
	assign ref_generator_enable = converter_mode_reg[MODE_REF_BIT];
	assign powerfail_compare_enable = powerfail_mode_reg[PF_EN_BIT];
	assign powerfail_compare_polarity = powerfail_mode_reg[PF_POL_BIT];

	////////////////////////////////////////////////////////////////
	// Read path and wait cycle

	always_comb begin
		if (hit_mode)
			next_rdata = converter_mode_reg;
		else if (hit_chan)
			next_rdata = channel_select_reg;
		else if (hit_pf_mode)
			next_rdata = powerfail_mode_reg;
		else if (hit_pf_thresh)
			next_rdata = powerfail_threshold_reg;
		else if (hit_res_hi)
			next_rdata = conversion_result_reg[RES_BITS-1:2]; // [R7]
		else if (hit_res_lo)
			next_rdata = {conversion_result_reg[1:0],
				PAD_BITS'(0)}; // [R7]
		else
			next_rdata = 8'h00;
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			BUS_RDATA <= 8'h00;
		else if (BUS_RD)
			BUS_RDATA <= next_rdata;
	end

	// Writes to any control register, and result reads, stall the bus
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			BUS_WAIT <= 1'b0;
		else
			BUS_WAIT <= wr_mode || wr_chan || wr_pf_mode || wr_pf_thresh
				|| (BUS_RD && (hit_res_hi || hit_res_lo)); // [R17]
	end

	////////////////////////////////////////////////////////////////
	// Start, abort and restart

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			restart <= 1'b0;
		end else begin
			// Any control write restarts from sampling if run is set
			restart <= wr_mode || wr_chan || wr_pf_mode
				|| wr_pf_thresh; // [R20]
		end
	end

	// Mode lags the control bits one cycle, so it also marks run rising
	always_comb begin
		next_op_state = op_state;
		case (op_state)
			ST_STOPPED: begin
				if (conversion_run)
					next_op_state = ST_CONVERTING;
				else if (ref_generator_enable)
					next_op_state = ST_WAITING;
			end
			ST_WAITING: begin
				if (conversion_run)
					next_op_state = ST_CONVERTING;
				else if (!ref_generator_enable)
					next_op_state = ST_STOPPED;
			end
			ST_CONVERTING: begin
				if (!conversion_run)
					next_op_state = ref_generator_enable
						? ST_WAITING : ST_STOPPED;
			end
			default: next_op_state = ST_STOPPED;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			op_state <= ST_STOPPED;
		else
			op_state <= next_op_state; // [R14]
	end

	assign seq.run = conversion_run; // [R14]
	assign seq.restart = restart;
	assign seq.period = bit_period(
		converter_mode_reg[MODE_TSEL_MSB:MODE_TSEL_LSB]); // [R10]
	assign seq.cmp_in = CMP_IN;

	sacpf_timer u_timer (
		.clk(CORE_CLK),
		.rst(RESET),
		.seq(seq)
	);

	sacpf_sar u_sar (
		.clk(CORE_CLK),
		.rst(RESET),
		.seq(seq)
	);

	////////////////////////////////////////////////////////////////
	// Reference generator settling and first-result validity

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			ref_cnt <= '0;
		else if (!ref_generator_enable)
			ref_cnt <= '0;
		else if (!ref_ready)
			ref_cnt <= ref_cnt + REF_CNT_W'(1); // [R12]
	end

	assign ref_ready = (ref_cnt == REF_CNT_W'(REF_SETTLE_CYC));

	// Reference not settled at run start spoils the first result only
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			first_bad <= 1'b0;
		else if (conversion_run && op_state != ST_CONVERTING)
			first_bad <= !ref_ready; // [R15] [R13]
		else if (seq.done)
			first_bad <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Result capture and interrupt

	assign cond_ge = seq.result[RES_BITS-1:2] >= powerfail_threshold_reg;
	// Polarity zero fires on at-or-above, one fires on below
	assign fire = !powerfail_compare_enable
		|| (cond_ge ^ powerfail_compare_polarity); // [R3] [R18]

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			conversion_result_reg <= '0;
		else if (seq.done)
			conversion_result_reg <= seq.result; // [R7] [R6]
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			CONV_DONE_IRQ <= 1'b0;
		else
			CONV_DONE_IRQ <= seq.done && fire && !first_bad; // [R2] [R15]
	end

	////////////////////////////////////////////////////////////////
	// Analog side and shared port pins

	assign SH_SAMPLE = seq.sample; // [R5]
	assign TAP_CODE = seq.approx; // [R1]

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			CHANNEL_SEL <= 2'h0;
			REF_GEN_EN <= 1'b0;
			PORT_DATA <= 4'h0;
		end else begin
			CHANNEL_SEL <= channel_select_reg[1:0]; // [R1] [R19]
			REF_GEN_EN <= ref_generator_enable; // [R12] [R14]
			// Only the selected pin is blanked while converting
			PORT_DATA <= PIN_IN & ~(conversion_run
				? (4'h1 << channel_select_reg[1:0]) : 4'h0); // [R4]
		end
	end

endmodule
`default_nettype wire

// ---- sacpf_checker_assertions.sv ----
// Port-level checks for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sacpf_checker (
	input wire logic CORE_CLK, // Clock
	input wire logic RESET, // Reset
	input wire logic [15:0] BUS_ADDR, // Address
	input wire logic BUS_WR, // Byte write
	input wire logic [7:0] BUS_WDATA, // Write data
	input wire logic BUS_WAIT, // Wait cycle
	input wire logic [3:0] PIN_IN, // Pin levels
	input wire logic [3:0] PORT_DATA, // Port data
	input wire logic [1:0] CHANNEL_SEL, // Channel
	input wire logic SH_SAMPLE, // Sample or hold
	input wire logic [9:0] TAP_CODE, // Tap code
	input wire logic REF_GEN_EN, // Reference power
	input wire logic CONV_DONE_IRQ // Done pulse
);
	import sacpf_pkg::*;
	logic [9:0] low_bit;
	logic [3:0] sel_mask;
	// Lowest set bit marks the trial in progress
	assign low_bit = TAP_CODE & (~TAP_CODE + 10'h001);
	assign sel_mask = 4'h1 << CHANNEL_SEL;
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);
	a_mode_wait: assert property (BUS_WR && BUS_ADDR == ADDR_MODE |=> BUS_WAIT)
		else $error("no wait cycle after mode write");
	a_ref_follow: assert property (BUS_WR && BUS_ADDR == ADDR_MODE |-> ##2
		REF_GEN_EN == $past(BUS_WDATA[0], 2)) else $error("reference power wrong");
	a_chan_follow: assert property (BUS_WR && BUS_ADDR == ADDR_CHAN |-> ##2
		CHANNEL_SEL == $past(BUS_WDATA[1:0], 2)) else $error("channel wrong");
	a_stop_idle: assert property (BUS_WR && BUS_ADDR == ADDR_MODE
		&& !BUS_WDATA[7] |-> ##3 (!SH_SAMPLE && TAP_CODE == 10'h000))
		else $error("converter not stopped");
	a_sample_tap: assert property (SH_SAMPLE |-> TAP_CODE == 10'h000)
		else $error("tap active while sampling");
	a_hold_msb: assert property ($fell(SH_SAMPLE) && TAP_CODE != 10'h000
		|-> TAP_CODE == 10'h200) else $error("first trial not the top bit");
	a_trial_step: assert property (!SH_SAMPLE && $changed(TAP_CODE)
		&& TAP_CODE != 10'h000 && $past(TAP_CODE) != 10'h000
		|-> low_bit == ($past(low_bit) >> 1)) else $error("trial order wrong");
	a_irq_capture: assert property (CONV_DONE_IRQ
		|-> $past(SH_SAMPLE) && !$past(SH_SAMPLE, 2))
		else $error("done pulse not after capture");
	a_port_pass: assert property (!$past(RESET)
		|-> (PORT_DATA | sel_mask) == ($past(PIN_IN) | sel_mask))
		else $error("port data does not follow pins");
	a_port_block: assert property (SH_SAMPLE |-> !PORT_DATA[CHANNEL_SEL])
		else $error("selected pin not masked");
endmodule
bind sacpf_top sacpf_checker i_sacpf_checker (.CORE_CLK(CORE_CLK),
	.RESET(RESET), .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR),
	.BUS_WDATA(BUS_WDATA), .BUS_WAIT(BUS_WAIT), .PIN_IN(PIN_IN),
	.PORT_DATA(PORT_DATA), .CHANNEL_SEL(CHANNEL_SEL),
	.SH_SAMPLE(SH_SAMPLE), .TAP_CODE(TAP_CODE), .REF_GEN_EN(REF_GEN_EN),
	.CONV_DONE_IRQ(CONV_DONE_IRQ));
`default_nettype wire

// ---- sacpf_analog_model.sv ----
// Behavioural selector, sample-and-hold and comparator
`timescale 1ns/100ps
`default_nettype none
module sacpf_analog_model #(
	parameter int SETTLE = 1 // Cycles the comparator needs after a tap move
) (
	input wire logic clk, // Main clock
	input wire logic [39:0] level, // Four 10-bit channel levels
	input wire logic [1:0] chan, // Selected channel
	input wire logic sample, // High sample, low hold
	input wire logic [9:0] tap, // Tap code
	output logic cmp // Input at or above tap
);
	logic [9:0] held = 10'h000;
	logic [9:0] last_tap = 10'h000;
	int age = 0;
	// Track the pin only while sampling, freeze in hold
	always @(posedge clk) begin
		if (sample)
			held <= level[chan*10 +: 10];
		age <= (tap != last_tap) ? 0 : ((age < SETTLE) ? age + 1 : age);
		last_tap <= tap;
	end
	// Unsettled tap gives the wrong answer, so early sampling shows
	assign cmp = (tap == last_tap && age >= SETTLE) ? held >= tap : held < tap;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import sacpf_pkg::*;
	logic CORE_CLK = 1'b0;
	logic RESET = 1'b1;
	logic [15:0] BUS_ADDR = 16'h0000;
	logic BUS_WR = 1'b0;
	logic BUS_BIT_WR = 1'b0;
	logic [2:0] BUS_BIT_NUM = 3'h0;
	logic [7:0] BUS_WDATA = 8'h00;
	logic BUS_RD = 1'b0;
	logic [3:0] PIN_IN = 4'h0;
	logic [39:0] level = 40'h0;
	wire logic CMP_IN, BUS_WAIT, SH_SAMPLE, REF_GEN_EN, CONV_DONE_IRQ;
	wire logic [7:0] BUS_RDATA;
	wire logic [3:0] PORT_DATA;
	wire logic [1:0] CHANNEL_SEL;
	wire logic [9:0] TAP_CODE;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int seed = 39;
	int n;
	logic [7:0] rd, thr;
	logic w, pol;
	logic [9:0] v;
	logic [1:0] ch;
	logic [15:0] addrs [5] = '{ADDR_MODE, ADDR_CHAN, ADDR_PF_MODE,
		ADDR_PF_THRESH, 16'hff30};
	logic [7:0] masks [5] = '{8'hb9, 8'h03, 8'hc0, 8'hff, 8'h00};
	logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
	int cyc [6] = '{288, 240, 192, 144, 120, 96};

	sacpf_top i_sacpf_top (.CORE_CLK(CORE_CLK), .RESET(RESET),
		.BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR), .BUS_BIT_WR(BUS_BIT_WR),
		.BUS_BIT_NUM(BUS_BIT_NUM), .BUS_WDATA(BUS_WDATA), .BUS_RD(BUS_RD),
		.BUS_RDATA(BUS_RDATA), .BUS_WAIT(BUS_WAIT), .CMP_IN(CMP_IN),
		.PIN_IN(PIN_IN), .PORT_DATA(PORT_DATA), .CHANNEL_SEL(CHANNEL_SEL),
		.SH_SAMPLE(SH_SAMPLE), .TAP_CODE(TAP_CODE), .REF_GEN_EN(REF_GEN_EN),
		.CONV_DONE_IRQ(CONV_DONE_IRQ));
	sacpf_analog_model i_sacpf_analog_model (.clk(CORE_CLK), .level(level),
		.chan(CHANNEL_SEL), .sample(SH_SAMPLE), .tap(TAP_CODE), .cmp(CMP_IN));

	always #10 CORE_CLK = ~CORE_CLK;
	always @(negedge CORE_CLK)
		PIN_IN <= 4'($random(seed));
	// Generous ceiling; the planned run is near 6000 cycles
	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			$display("unexpected at %0t: run timed out", $time);
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////
	function automatic logic want(input logic p, input logic [7:0] hi,
		input logic [7:0] t);
		want = (hi >= t) ^ p;
	endfunction
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Kind 0 byte write, 1 bit write, 2 read; idle cycle covers the wait
	task automatic bus(input int kind, input logic [15:0] a,
		input logic [7:0] d, input logic [2:0] b);
		@(negedge CORE_CLK);
		BUS_ADDR = a;
		BUS_WDATA = d;
		BUS_BIT_NUM = b;
		BUS_WR = (kind == 0);
		BUS_BIT_WR = (kind == 1);
		BUS_RD = (kind == 2);
		@(negedge CORE_CLK);
		{BUS_WR, BUS_BIT_WR, BUS_RD} = 3'b000;
		rd = BUS_RDATA;
		w = BUS_WAIT;
		@(negedge CORE_CLK);
	endtask
	task automatic wait_irq(input int lim);
		n = 0;
		do begin
			@(negedge CORE_CLK);
			n++;
		end while (CONV_DONE_IRQ !== 1'b1 && n < lim);
	endtask
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
		RESET = 1'b0;
		for (int i = 0; i < 5; i++) begin
			bus(2, addrs[i], 8'h00, 3'h0);
			check(10'(rd), 10'h000);
			bus(0, addrs[i], 8'hff, 3'h0);
			check(10'(w), 10'(i < 4));
			bus(2, addrs[i], 8'h00, 3'h0);
			check(10'(rd), 10'(masks[i]));
			if (i == 0)
				bus(1, ADDR_MODE, 8'h00, 3'h7);
			bus(0, addrs[i], 8'h00, 3'h0);
		end
		bus(1, ADDR_MODE, 8'h01, 3'h0);
		bus(1, ADDR_PF_THRESH, 8'h01, 3'h3);
		bus(2, ADDR_MODE, 8'h00, 3'h0);
		check(10'(rd), 10'h001);
		bus(2, ADDR_PF_THRESH, 8'h00, 3'h0);
		check(10'(rd), 10'h000);
		repeat (700) @(negedge CORE_CLK);
		check(10'(REF_GEN_EN), 10'h001);
		$display("registers test done");
		for (int i = 0; i < 6; i++) begin
			level = {$random(seed), 8'($random(seed))};
			ch = 2'($random(seed));
			v = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($random(seed));
			level[ch*10 +: 10] = v;
			bus(1, ADDR_MODE, 8'h00, 3'h7);
			bus(0, ADDR_CHAN, {6'h00, ch}, 3'h0);
			// All six codes shorten the run below the software floor
			bus(0, ADDR_MODE, 8'h81 | {2'b00, codes[i], 3'h0}, 3'h0);
			wait_irq(1000);
			wait_irq(1000);
			check(10'(n), 10'(cyc[i]));
			bus(2, ADDR_RESULT_HI, 8'h00, 3'h0);
			check(10'(rd), {2'b00, v[9:2]});
			bus(2, ADDR_RESULT_LO, 8'h00, 3'h0);
			check(10'(rd), {2'b00, v[1:0], 6'h00});
		end
		$display("conversion test done");
		bus(1, ADDR_MODE, 8'h00, 3'h7);
		bus(0, ADDR_MODE, 8'h00, 3'h0);
		bus(0, ADDR_MODE, 8'h80, 3'h0);
		wait_irq(2000);
		check(10'(n > 360), 10'h001);
		check(10'(REF_GEN_EN), 10'h000);
		bus(0, ADDR_MODE, 8'h00, 3'h0);
		wait_irq(400);
		check(10'(n), 10'd400);
		check({SH_SAMPLE, TAP_CODE[8:0]}, 10'h000);
		$display("stop test done");
		bus(0, ADDR_MODE, 8'h01, 3'h0);
		repeat (700) @(negedge CORE_CLK);
		bus(0, ADDR_MODE, 8'hb1, 3'h0);
		for (int k = 0; k < 4; k++) begin
			thr = 8'($random(seed)) | 8'h02;
			pol = k[0];
			v = k[1] ? {thr, 2'b00} : {thr - 8'h01, 2'b11};
			level = {4{v}};
			bus(0, ADDR_PF_THRESH, thr, 3'h0);
			bus(0, ADDR_PF_MODE, {1'b1, pol, 6'h00}, 3'h0);
			wait_irq(300);
			check(10'(n < 300), 10'(want(pol, v[9:2], thr)));
		end
		$display("threshold test done");
		bus(0, ADDR_PF_MODE, 8'h00, 3'h0);
		wait_irq(300);
		repeat (40) @(negedge CORE_CLK);
		bus(0, ADDR_PF_THRESH, 8'h00, 3'h0);
		wait_irq(300);
		check(10'(n > 80 && n < 300), 10'h001);
		$display("abort test done");
		close_out();
	end
endmodule
`default_nettype wire
